// ---- src/pcc_cache.sv ----
/*
 * paged cpu cache controller: cpu request port, page translation, two-way
 * lookup, line fill, write-back and bypass over a single-transfer bus master.
 * assumes cpu holds its request until cpu_ready, and bus slaves answer okay.
 */
`timescale 1ns/100ps
module pcc_cache
	import pcc_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    rstn,
	input  wire logic                    cpu_req,
	input  wire logic                    cpu_we,
	input  wire logic                    cpu_instr,
	input  wire logic [31:0]             cpu_addr,
	input  wire logic [31:0]             cpu_wdata,
	output logic      [31:0]             cpu_rdata,
	output logic                         cpu_ready,
	input  wire logic [1:0]              cache_mode,
	input  wire logic [PAGES-1:0]        page_en,
	input  wire logic [PAGES*BASE_W-1:0] page_base,
	output logic      [31:0]             haddr,
	output logic      [1:0]              htrans,
	output logic                         hwrite,
	output logic      [2:0]              hsize,
	output logic      [31:0]             hwdata,
	input  wire logic [31:0]             hrdata,
	input  wire logic                    hready
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_PREP, ST_WB_ADDR, ST_WB_DATA,
		ST_FILL_ADDR, ST_FILL_DATA, ST_BY_ADDR, ST_BY_DATA
	} pcc_state_e;

	// ==========================================================
	// translation and cacheability
	logic [PG_W-1:0]   cpu_page;
	logic              in_region;
	logic [BASE_W-1:0] cpu_base;
	logic [31:0]       bus_addr;
	logic              cacheable;

	assign cpu_page  = cpu_addr[PG_LSB +: PG_W];
	assign in_region = (cpu_addr[31:REG_LSB] == '0);
	assign cpu_base  = page_base[cpu_page*BASE_W +: BASE_W];
	assign bus_addr  = (in_region && page_en[cpu_page]) ?
	                   {cpu_base, cpu_addr[PG_LSB-1:0]} : cpu_addr;
	assign cacheable = in_region && page_en[cpu_page] &&
	                   (cpu_instr ? cache_mode[MODE_INSTR] : cache_mode[MODE_DATA]);

	// ==========================================================
	// state
	pcc_state_e        state, next_state;
	logic [31:0]       req_addr, next_req_addr;
	logic              req_we, next_req_we;
	logic [31:0]       req_wdata, next_req_wdata;
	logic              req_fill, next_req_fill;
	logic              req_wb, next_req_wb;
	logic              cur_way, next_cur_way;
	logic [TAG_W-1:0]  vic_tag, next_vic_tag;
	logic [WRD_W-1:0]  beat, next_beat;
	logic [SETS-1:0]   lru, next_lru;
	logic [31:0]       next_cpu_rdata;
	logic              next_cpu_ready;
	logic [31:0]       next_haddr;
	logic [1:0]        next_htrans;
	logic              next_hwrite;
	logic [31:0]       next_hwdata;

	// ==========================================================
	// way array
	logic [IDX_W-1:0]  rd_idx;
	logic [WRD_W-1:0]  rd_word;
	logic [TAG_W-1:0]  w_tag [WAYS];
	logic [31:0]       w_data [WAYS];
	logic [WAYS-1:0]   w_valid;
	logic [WAYS-1:0]   w_dirty;
	logic [WAYS-1:0]   w_hit;
	logic [WAYS-1:0]   w_wr;
	logic [WAYS-1:0]   w_mark;
	logic [WAYS-1:0]   w_alloc;
	logic [WRD_W-1:0]  wr_word;
	logic [31:0]       wr_data;
	logic              victim;
	logic              lookup;

	// lookup uses the live cpu address only while idle; otherwise the latched line
	assign rd_idx  = (state == ST_IDLE) ? bus_addr[IDX_LSB +: IDX_W] :
	                 req_addr[IDX_LSB +: IDX_W];
	assign rd_word = (state == ST_IDLE) ? bus_addr[2 +: WRD_W] : beat;
	assign lookup  = (state == ST_IDLE) && cpu_req && cacheable;

	genvar gw;
	generate
		for (gw = 0; gw < WAYS; gw++) begin : g_way
			assign w_hit[gw] = w_valid[gw] && (w_tag[gw] == bus_addr[31:TAG_LSB]);
			pcc_way u_way (
				.core_clk   (core_clk),
				.rstn       (rstn),
				.rd_idx     (rd_idx),
				.rd_word    (rd_word),
				.rd_tag     (w_tag[gw]),
				.rd_valid   (w_valid[gw]),
				.rd_dirty   (w_dirty[gw]),
				.rd_data    (w_data[gw]),
				.wr_en      (w_wr[gw]),
				.wr_idx     (rd_idx),
				.wr_word    (wr_word),
				.wr_data    (wr_data),
				.mark_dirty (w_mark[gw]),
				.line_alloc (w_alloc[gw]),
				.alloc_tag  (req_addr[31:TAG_LSB])
			);
		end
	endgenerate

	assign victim = !w_valid[0] ? 1'b0 : (!w_valid[1] ? 1'b1 : lru[rd_idx]);

	// ==========================================================
	// controller
	always_comb begin
		next_state     = state;
		next_req_addr  = req_addr;
		next_req_we    = req_we;
		next_req_wdata = req_wdata;
		next_req_fill  = req_fill;
		next_req_wb    = req_wb;
		next_cur_way   = cur_way;
		next_vic_tag   = vic_tag;
		next_beat      = beat;
		next_lru       = lru;
		next_cpu_rdata = cpu_rdata;
		next_cpu_ready = 1'b0;
		next_haddr     = haddr;
		next_htrans    = HT_IDLE;
		next_hwrite    = hwrite;
		next_hwdata    = hwdata;
		w_wr           = '0;
		w_mark         = '0;
		w_alloc        = '0;
		wr_word        = rd_word;
		wr_data        = cpu_wdata;
		unique case (state)
			ST_IDLE: begin
				if (cpu_req) begin
					next_req_addr  = bus_addr;
					next_req_we    = cpu_we;
					next_req_wdata = cpu_wdata;
					next_req_fill  = 1'b0;
					next_req_wb    = 1'b0;
					next_beat      = '0;
					if (lookup && |w_hit) begin
						next_cpu_ready     = 1'b1;
						next_lru[rd_idx]   = ~w_hit[1];
						if (cpu_we) begin
							w_wr   = w_hit;
							w_mark = w_hit;
						end else begin
							next_cpu_rdata = w_hit[1] ? w_data[1] : w_data[0];
						end
					end else begin
						next_state = ST_PREP;
						if (lookup && !cpu_we) begin
							next_req_fill = 1'b1;
							next_cur_way  = victim;
							next_vic_tag  = w_tag[victim];
							next_req_wb   = w_valid[victim] && w_dirty[victim];
						end
					end
				end
			end
			ST_PREP: begin
				// the extra wait costs one cycle on every bus-going access
				next_htrans = HT_NONSEQ;
				if (req_wb) begin
					next_state  = ST_WB_ADDR;
					next_haddr  = {vic_tag, req_addr[IDX_LSB +: IDX_W], beat, 2'b00};
					next_hwrite = 1'b1;
				end else if (req_fill) begin
					next_state  = ST_FILL_ADDR;
					next_haddr  = {req_addr[31:IDX_LSB], beat, 2'b00};
					next_hwrite = 1'b0;
				end else begin
					next_state  = ST_BY_ADDR;
					next_haddr  = req_addr;
					next_hwrite = req_we;
				end
			end
			ST_WB_ADDR: begin
				if (hready) begin
					next_state  = ST_WB_DATA;
					next_hwdata = w_data[cur_way];
				end else begin
					next_htrans = HT_NONSEQ;
				end
			end
			ST_WB_DATA: begin
				if (hready) begin
					next_beat   = beat + 1'b1;
					next_htrans = HT_NONSEQ;
					if (beat == WRD_W'(LINE_WRDS - 1)) begin
						next_state  = ST_FILL_ADDR;
						next_hwrite = 1'b0;
						next_haddr  = {req_addr[31:IDX_LSB], next_beat, 2'b00};
					end else begin
						next_state  = ST_WB_ADDR;
						next_haddr  = {vic_tag, req_addr[IDX_LSB +: IDX_W], next_beat, 2'b00};
					end
				end else begin
					next_htrans = HT_IDLE;
				end
			end
			ST_FILL_ADDR: begin
				if (hready)
					next_state = ST_FILL_DATA;
				else
					next_htrans = HT_NONSEQ;
			end
			ST_FILL_DATA: begin
				if (hready) begin
					w_wr[cur_way] = 1'b1;
					wr_word       = beat;
					wr_data       = hrdata;
					if (beat == req_addr[2 +: WRD_W])
						next_cpu_rdata = hrdata;
					next_beat = beat + 1'b1;
					if (beat == WRD_W'(LINE_WRDS - 1)) begin
						// cpu is released only once the whole line is in
						w_alloc[cur_way] = 1'b1;
						next_lru[rd_idx] = ~cur_way;
						next_cpu_ready   = 1'b1;
						next_state       = ST_IDLE;
					end else begin
						next_state  = ST_FILL_ADDR;
						next_htrans = HT_NONSEQ;
						next_haddr  = {req_addr[31:IDX_LSB], next_beat, 2'b00};
					end
				end
			end
			ST_BY_ADDR: begin
				if (hready) begin
					next_state  = ST_BY_DATA;
					next_hwdata = req_wdata;
				end else begin
					next_htrans = HT_NONSEQ;
				end
			end
			ST_BY_DATA: begin
				if (hready) begin
					if (!req_we)
						next_cpu_rdata = hrdata;
					next_cpu_ready = 1'b1;
					next_state     = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state     <= ST_IDLE;
			req_addr  <= RST_WORD;
			req_we    <= 1'b0;
			req_wdata <= RST_WORD;
			req_fill  <= 1'b0;
			req_wb    <= 1'b0;
			cur_way   <= 1'b0;
			vic_tag   <= '0;
			beat      <= '0;
			lru       <= '0;
			cpu_rdata <= RST_WORD;
			cpu_ready <= 1'b0;
			haddr     <= RST_WORD;
			htrans    <= HT_IDLE;
			hwrite    <= 1'b0;
			hsize     <= HSIZE_WORD;
			hwdata    <= RST_WORD;
		end else begin
			state     <= next_state;
			req_addr  <= next_req_addr;
			req_we    <= next_req_we;
			req_wdata <= next_req_wdata;
			req_fill  <= next_req_fill;
			req_wb    <= next_req_wb;
			cur_way   <= next_cur_way;
			vic_tag   <= next_vic_tag;
			beat      <= next_beat;
			lru       <= next_lru;
			cpu_rdata <= next_cpu_rdata;
			cpu_ready <= next_cpu_ready;
			haddr     <= next_haddr;
			htrans    <= next_htrans;
			hwrite    <= next_hwrite;
			hsize     <= HSIZE_WORD;
			hwdata    <= next_hwdata;
		end
	end

	// ==========================================================
	// checks
	AST_READ_HIT: assert property (@(posedge core_clk) disable iff (!rstn)
		lookup && |w_hit && !cpu_we |=> cpu_ready && state == ST_IDLE)
		else $error("read hit not answered next cycle");
	AST_WRITE_HIT: assert property (@(posedge core_clk) disable iff (!rstn)
		lookup && |w_hit && cpu_we |=> cpu_ready && htrans == HT_IDLE)
		else $error("write hit went to the bus");
	AST_BYPASS: assert property (@(posedge core_clk) disable iff (!rstn)
		state == ST_IDLE && cpu_req && !cacheable |=> state == ST_PREP && !req_fill)
		else $error("uncached access did not bypass");
	AST_EXTRA_WAIT: assert property (@(posedge core_clk) disable iff (!rstn)
		state == ST_PREP |-> htrans == HT_IDLE ##1 htrans == HT_NONSEQ)
		else $error("extra wait missing before bus access");
	AST_FILL_ADDR: assert property (@(posedge core_clk) disable iff (!rstn)
		state == ST_FILL_ADDR |-> !hwrite && haddr[4:2] == beat)
		else $error("fill address does not follow beat");
	AST_FILL_END: assert property (@(posedge core_clk) disable iff (!rstn)
		state == ST_FILL_DATA && hready && beat == 3'h7 |=> cpu_ready && state == ST_IDLE)
		else $error("line fill did not release cpu");
	AST_WB_WRITE: assert property (@(posedge core_clk) disable iff (!rstn)
		state == ST_WB_ADDR |-> hwrite && haddr[31:TAG_LSB] == vic_tag)
		else $error("write-back not aimed at victim");
	AST_WB_THEN_FILL: assert property (@(posedge core_clk) disable iff (!rstn)
		state == ST_WB_DATA && hready && beat == 3'h7 |=> state == ST_FILL_ADDR)
		else $error("fill did not follow write-back");
	AST_ALLOC_ONLY_FILL: assert property (@(posedge core_clk) disable iff (!rstn)
		|w_alloc |-> state == ST_FILL_DATA && !req_we)
		else $error("line allocated outside read fill");
	COV_READ_HIT: cover property (@(posedge core_clk) lookup && |w_hit && !cpu_we);
	COV_WRITE_HIT: cover property (@(posedge core_clk) lookup && |w_hit && cpu_we);
	COV_WRITE_BACK: cover property (@(posedge core_clk) state == ST_WB_DATA ##1 state == ST_FILL_ADDR);
	COV_BYPASS: cover property (@(posedge core_clk) state == ST_BY_DATA && hready);
endmodule

// ---- src/pcc_pkg.sv ----
/*
 * shared constants for the paged cpu cache controller: geometry, page decode,
 * mode bits, bus encodings and reset values.
 * assumes one clock domain and a single-master ahb-lite style port.
 */
// What this block does
// - two ways per set, two candidate lines
// - eight kilobytes, holds code and data
// - read hit answers with no wait
// - bus-going access gets one extra wait
// - read miss fills eight words, cpu stalls
// - write miss goes straight to memory
// - write hit updates line, marks dirty
// - dirty victim written back before fill
// - mode selects data, instruction or unified
// - sixteen pages of two megabytes each
// - pages span lowest thirty-two megabytes
// - per-page enable gates base and caching
package pcc_pkg;
	// ==========================================================
	// geometry
	localparam int WAYS      = 2;
	localparam int LINE_WRDS = 8;
	localparam int WRD_W     = 3;
	localparam int IDX_W     = 7;
	localparam int SETS      = 128;
	localparam int TAG_W     = 20;
	localparam int IDX_LSB   = 5;
	localparam int TAG_LSB   = 12;
	// ==========================================================
	// page decode
	localparam int PAGES     = 16;
	localparam int PG_LSB    = 21;
	localparam int PG_W      = 4;
	localparam int BASE_W    = 11;
	localparam int REG_LSB   = 25;
	// ==========================================================
	// cache mode field: bit0 data, bit1 instruction
	localparam int MODE_DATA  = 0;
	localparam int MODE_INSTR = 1;
	// ==========================================================
	// bus encodings and reset values
	localparam logic [1:0]  HT_IDLE    = 2'h0;
	localparam logic [1:0]  HT_NONSEQ  = 2'h2;
	localparam logic [2:0]  HSIZE_WORD = 3'h2;
	localparam logic [31:0] RST_WORD   = 32'h0000_0000;
endpackage

// ---- src/pcc_way.sv ----
/*
 * one way of the cache: tag, valid, dirty and line data storage.
 * assumes a data write and a tag allocation in one cycle share one set index.
 */
`timescale 1ns/100ps
module pcc_way
	import pcc_pkg::*;
(
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic [IDX_W-1:0] rd_idx,
	input  wire logic [WRD_W-1:0] rd_word,
	output logic      [TAG_W-1:0] rd_tag,
	output logic                  rd_valid,
	output logic                  rd_dirty,
	output logic      [31:0]      rd_data,
	input  wire logic             wr_en,
	input  wire logic [IDX_W-1:0] wr_idx,
	input  wire logic [WRD_W-1:0] wr_word,
	input  wire logic [31:0]      wr_data,
	input  wire logic             mark_dirty,
	input  wire logic             line_alloc,
	input  wire logic [TAG_W-1:0] alloc_tag
);
	logic [TAG_W-1:0] tag_mem [SETS];
	logic [31:0]      data_mem [SETS*LINE_WRDS];
	logic [SETS-1:0]  valid;
	logic [SETS-1:0]  dirty;
	logic [SETS-1:0]  next_valid;
	logic [SETS-1:0]  next_dirty;

	assign rd_tag   = tag_mem[rd_idx];
	assign rd_valid = valid[rd_idx];
	assign rd_dirty = dirty[rd_idx];
	assign rd_data  = data_mem[{rd_idx, rd_word}];

	always_comb begin
		next_valid = valid;
		next_dirty = dirty;
		if (line_alloc) begin
			next_valid[wr_idx] = 1'b1;
			next_dirty[wr_idx] = 1'b0;
		end
		if (mark_dirty)
			next_dirty[wr_idx] = 1'b1;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			valid <= '0;
			dirty <= '0;
		end else begin
			valid <= next_valid;
			dirty <= next_dirty;
		end
	end

	// storage has no reset; valid bits guard it
	always_ff @(posedge core_clk) begin
		if (wr_en)
			data_mem[{wr_idx, wr_word}] <= wr_data;
		if (line_alloc)
			tag_mem[wr_idx] <= alloc_tag;
	end
endmodule

// ---- tb/pcc_cache_tb_top.sv ----
/*
 * self-checking bench for the paged cache: hits, fills, write-back, modes.
 * assumes page 1 relocated to base 11'h010 and the memory model on the bus.
 */
`timescale 1ns/100ps
module pcc_cache_tb_top
	import pcc_pkg::*;
;
	logic                    core_clk;
	logic                    rstn;
	logic                    cpu_req;
	logic                    cpu_we;
	logic                    cpu_instr;
	logic [31:0]             cpu_addr;
	logic [31:0]             cpu_wdata;
	logic [31:0]             cpu_rdata;
	logic                    cpu_ready;
	logic [1:0]              cache_mode;
	logic [PAGES-1:0]        page_en;
	logic [PAGES*BASE_W-1:0] page_base;
	logic [31:0]             haddr;
	logic [1:0]              htrans;
	logic                    hwrite;
	logic [2:0]              hsize;
	logic [31:0]             hwdata;
	logic [31:0]             hrdata;
	logic                    hready;
	logic [3:0]              wait_cnt;
	int                      error_cnt = 0;
	int                      n_tests = 0;

	pcc_cache dut_u (.core_clk(core_clk), .rstn(rstn), .cpu_req(cpu_req), .cpu_we(cpu_we),
		.cpu_instr(cpu_instr), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
		.cpu_rdata(cpu_rdata), .cpu_ready(cpu_ready), .cache_mode(cache_mode),
		.page_en(page_en), .page_base(page_base), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hready(hready));
	pcc_mem_model mem_u (.core_clk(core_clk), .rstn(rstn), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata), .wait_cnt(wait_cnt), .hrdata(hrdata),
		.hready(hready));

	// ==========================================================
	// compares and drivers
	task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_n(input string nm, input int exp, input int got);
		n_tests++;
		if (got != exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	// request held until cpu_ready shows after an edge; cycles counted from launch
	task automatic cpu_op(input logic we, input logic ins, input logic [31:0] a,
		input logic [31:0] wd, input int exp_cyc, input logic [31:0] exp_rd);
		int cyc;
		cyc = 0;
		mem_u.trq.delete();
		cpu_req = 1'b1;
		cpu_we = we;
		cpu_instr = ins;
		cpu_addr = a;
		cpu_wdata = wd;
		do begin
			@(posedge core_clk);
			#1;
			cyc++;
		end while (cpu_ready !== 1'b1 && cyc < 200);
		chk_n("cycles", exp_cyc, cyc);
		if (!we)
			chk32("cpu_rdata", exp_rd, cpu_rdata);
	endtask

	task automatic chk_bus(input int n, input int first, input logic we,
		input logic [31:0] a0, input int beats);
		chk_n("bus count", n, mem_u.trq.size());
		for (int k = 0; k < beats; k++) begin
			if (first + k < mem_u.trq.size()) begin
				chk32("bus addr", a0 + 32'(4 * k), mem_u.trq[first+k][63:32]);
				chk32("bus dir", {31'h0, we}, {31'h0, mem_u.trq[first+k][64]});
			end
		end
	endtask

	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_paged_rw();
		cache_mode = 2'h3;
		cpu_op(0, 0, 32'h0020_0200, 0, 4, ~32'h0020_0200);
		chk_bus(1, 0, 0, 32'h0020_0200, 1);
		page_en = 16'h0002;
		cpu_op(0, 0, 32'h0020_0104, 0, 18, ~32'h0200_0104);
		chk_bus(8, 0, 0, 32'h0200_0100, 8);
		cpu_op(0, 0, 32'h0020_0104, 0, 1, ~32'h0200_0104);
		chk_bus(0, 0, 0, 0, 0);
		cpu_op(1, 0, 32'h0020_0104, 32'hcafe_0001, 1, 0);
		chk_bus(0, 0, 0, 0, 0);
		cpu_op(0, 0, 32'h0020_0104, 0, 1, 32'hcafe_0001);
		cpu_op(1, 0, 32'h0020_0800, 32'hbeef_0002, 4, 0);
		chk_bus(1, 0, 1, 32'h0200_0800, 1);
		chk32("wr data", 32'hbeef_0002, mem_u.trq[0][31:0]);
		cpu_op(0, 0, 32'h0020_0800, 0, 18, 32'hbeef_0002);
	endtask

	task automatic t_victim();
		cpu_op(0, 0, 32'h0020_1104, 0, 18, ~32'h0200_1104);
		chk_bus(8, 0, 0, 32'h0200_1100, 8);
		cpu_op(0, 0, 32'h0020_2104, 0, 34, ~32'h0200_2104);
		chk_bus(16, 0, 1, 32'h0200_0100, 8);
		chk_bus(16, 8, 0, 32'h0200_2100, 8);
		chk32("wb data", 32'hcafe_0001, mem_u.trq[1][31:0]);
		cpu_op(0, 0, 32'h0020_1104, 0, 1, ~32'h0200_1104);
		cpu_op(0, 0, 32'h0020_0104, 0, 18, 32'hcafe_0001);
		chk_bus(8, 0, 0, 32'h0200_0100, 8);
	endtask

	task automatic t_modes();
		logic [31:0] a;
		for (int m = 1; m < 3; m++) begin
			for (int it = 0; it < 2; it++) begin
				cache_mode = 2'(m);
				a = 32'h0020_4000 + 32'((m * 2 + it) * 64);
				cpu_op(0, it[0], a, 0, m[it] ? 18 : 4, ~{11'h010, a[20:0]});
				cpu_op(0, it[0], a, 0, m[it] ? 1 : 4, ~{11'h010, a[20:0]});
			end
		end
	endtask

	task automatic t_region();
		cache_mode = 2'h3;
		page_en = 16'hffff;
		wait_cnt = 4'h2;
		cpu_op(0, 1, 32'h1040_0010, 0, 6, ~32'h1040_0010);
		chk_bus(1, 0, 0, 32'h1040_0010, 1);
		wait_cnt = 4'h0;
		page_en = 16'hfffe;
		cpu_op(0, 0, 32'h0000_0100, 0, 4, ~32'h0000_0100);
		cpu_op(0, 0, 32'h0000_0100, 0, 4, ~32'h0000_0100);
		cpu_req = 1'b0;
	endtask

	// reset in mid-run must drop every valid line and quiet the outputs
	task automatic t_reset_mid();
		rstn = 1'b0;
		#1;
		chk32("rst cpu_ready", 32'h0, {31'h0, cpu_ready});
		chk32("rst cpu_rdata", RST_WORD, cpu_rdata);
		chk32("rst htrans", {30'h0, HT_IDLE}, {30'h0, htrans});
		@(posedge core_clk);
		#1;
		rstn = 1'b1;
		cpu_op(0, 0, 32'h0020_1104, 0, 18, ~32'h0200_1104);
		chk32("hsize", {29'h0, HSIZE_WORD}, {29'h0, hsize});
		cache_mode = 2'h0;
		cpu_op(0, 0, 32'h0020_1104, 0, 4, ~32'h0200_1104);
		cpu_op(0, 1, 32'h0020_1104, 0, 4, ~32'h0200_1104);
		cpu_req = 1'b0;
	endtask

	// ==========================================================
	// clock, reset, sequence, watchdog
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		rstn = 1'b0;
		cpu_req = 1'b0;
		cpu_we = 1'b0;
		cpu_instr = 1'b0;
		cpu_addr = 32'h0;
		cpu_wdata = 32'h0;
		cache_mode = 2'h0;
		page_en = '0;
		page_base = '0;
		page_base[BASE_W+:BASE_W] = 11'h010;
		wait_cnt = 4'h0;
		repeat (3) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		t_paged_rw();
		t_victim();
		t_modes();
		t_region();
		t_reset_mid();
		report_and_stop();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		report_and_stop();
	end
endmodule

// ---- tb/pcc_mem_model.sv ----
/*
 * behavioural bus memory facing the cache's master port; logs every transfer.
 * assumes single non-pipelined transfers; unwritten words read as ~address.
 */
`timescale 1ns/100ps
module pcc_mem_model
	import pcc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic [3:0]  wait_cnt,
	output logic      [31:0] hrdata,
	output logic             hready
);
	// ==========================================================
	// storage and transfer log {write, address, data}
	logic [31:0] mem [logic [31:0]];
	logic [64:0] trq [$];
	logic        dph;
	logic        dwr;
	logic [31:0] dadr;
	int          wleft;

	function automatic logic [31:0] rd_word(input logic [31:0] a);
		return mem.exists(a) ? mem[a] : ~a;
	endfunction

	// ==========================================================
	// address phase, data phase with optional stalls
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dph = 1'b0;
			hready <= 1'b1;
			hrdata <= 32'h0;
		end else begin
			if (dph && hready) begin
				if (dwr)
					mem[dadr] = hwdata;
				trq.push_back({dwr, dadr, dwr ? hwdata : rd_word(dadr)});
				dph = 1'b0;
			end
			if (hready && htrans == HT_NONSEQ) begin
				dph = 1'b1;
				dadr = haddr;
				dwr = hwrite;
				wleft = wait_cnt;
			end
			// released data lines toggle so stale values never match
			if (dph && wleft > 0) begin
				hready <= 1'b0;
				hrdata <= ~hrdata;
				wleft--;
			end else if (dph && !dwr) begin
				hready <= 1'b1;
				hrdata <= rd_word(dadr);
			end else begin
				hready <= 1'b1;
				hrdata <= ~hrdata;
			end
		end
	end
endmodule
